// file: hdl/charge_readout_control.sv
// event readout control of a 32-channel charge digitiser, with its fifo
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module result_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] fill;
  logic push;
  logic pop;

  assign in_ready_o = (fill != (AW+1)'(DEPTH));
  assign out_valid_o = (fill != '0);
  assign out_data_o = mem[rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (ce_i && push) begin
      mem[wp] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp <= '0;
      rp <= '0;
      fill <= '0;
    end else if (ce_i) begin
      if (flush_i) begin
        wp <= '0;
        rp <= '0;
        fill <= '0;
      end else begin
        if (push) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
        if (pop) rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
        fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule : result_fifo

////////////////////////////////////////////////////////////////////////////
module charge_readout_control
  import charge_readout_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  output logic bus_ack_o,
  input wire logic step_event_i,
  input wire logic step_word_i,
  input wire logic keep_below_level_i,
  input wire logic threshold_fine_i,
  input wire logic keep_overrange_i,
  input wire logic read_pointer_autostep_i,
  input wire logic keep_empty_events_i,
  input wire logic count_every_gate_i,
  input wire logic clear_data_i,
  input wire logic soft_reset_hold_i,
  input wire logic single_shot_reset_i,
  input wire logic front_reset_i,
  input wire logic front_reset_select_i,
  input wire logic gate_i,
  input wire logic veto_i,
  input wire logic abort_conversion_i,
  input wire logic [7:0] fast_clear_window_i,
  input wire logic busy_from_chain_i,
  input wire logic busy_source_jumper_i,
  input wire logic memory_test_i,
  input wire result_type result_i,
  input wire logic result_valid_i,
  output logic result_ready_o,
  output logic conversion_start_o,
  output logic charge_integrator_clear_o,
  output logic busy_o,
  output logic busy_led_o,
  output logic global_busy_o,
  output logic data_ready_o,
  output logic store_full_o,
  output logic store_empty_o,
  output logic [15:0] event_count_low_o,
  output logic [7:0] event_count_high_o
);
  logic [31:0] store [NUM_EVENTS*64];
  logic [15:0] thresh [NUM_CHAN];
  conv_state_type state;
  logic [4:0] wr_event;
  logic [4:0] rd_event;
  logic [5:0] rd_off;
  logic last_write;
  logic [23:0] event_count;
  logic [5:0] res_cnt;
  logic [5:0] acc_cnt;
  logic close_phase;
  logic [7:0] win_cnt;
  logic [7:0] hold_cnt;
  logic gate_q;
  logic abort_q;
  logic soft_reset;
  logic data_reset;
  logic gate_rise;
  logic abort_rise;
  logic stop_acq;
  logic gate_ok;
  logic ptr_equal;
  logic wr_step;
  logic rd_step_event;
  logic rd_step_word;
  logic hit_store;
  logic hit_thresh;
  result_type res;
  logic res_valid;
  logic res_pop;
  logic [15:0] thr_entry;
  logic below;
  logic accept;
  logic dat_we;
  logic close_write;
  logic [10:0] close_addr;
  logic [31:0] close_word;
  logic [31:0] cur_word;
  logic [31:0] dat_word;

  ////////////////////////////////////////////////////////////////////////
  // resets and gate qualification
  assign soft_reset = soft_reset_hold_i || single_shot_reset_i ||
                      (front_reset_i && front_reset_select_i);
  assign data_reset = soft_reset || clear_data_i ||
                      (front_reset_i && !front_reset_select_i);
  assign gate_rise = gate_i && !gate_q;
  assign abort_rise = abort_conversion_i && !abort_q;
  assign busy_o = (state != ST_IDLE) || data_reset || store_full_o ||
                  memory_test_i;
  assign busy_led_o = busy_o;
  assign global_busy_o = busy_o || busy_from_chain_i;
  assign stop_acq = busy_source_jumper_i ? global_busy_o : busy_o;
  assign gate_ok = gate_rise && !stop_acq && !veto_i &&
                   !abort_conversion_i;
  assign conversion_start_o = ce_i && gate_ok && (state == ST_IDLE);
  assign charge_integrator_clear_o = data_reset ||
    ((state == ST_CONV) && abort_rise && (win_cnt != 8'h00));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (ce_i) begin
      gate_q <= gate_i;
      abort_q <= abort_conversion_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gate counter
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_count <= '0;
    end else if (ce_i) begin
      if (data_reset) begin
        event_count <= '0;
      end else if (gate_rise && (count_every_gate_i || gate_ok)) begin
        event_count <= event_count + 24'h000001;
      end
    end
  end
  assign event_count_low_o = event_count[15:0];
  assign event_count_high_o = event_count[23:16];

  ////////////////////////////////////////////////////////////////////////
  // result fifo and zero suppression
  result_fifo #(
    .WIDTH($bits(result_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .flush_i(data_reset),
    .in_data_i(result_i),
    .in_valid_i(result_valid_i),
    .in_ready_o(result_ready_o),
    .out_data_o(res),
    .out_valid_o(res_valid),
    .out_ready_i(res_pop)
  );

  assign res_pop = res_valid && ((state == ST_CONV) || (state == ST_HOLD));
  assign thr_entry = thresh[res.channel];

  always_comb begin
    if (threshold_fine_i) begin
      below = (res.value[8:1] < thr_entry[THR_LEVEL_LSB +: 8]) &&
              (res.value[11:9] == 3'h0);
    end else begin
      below = res.value[11:4] < thr_entry[THR_LEVEL_LSB +: 8];
    end
  end

  assign accept = !thr_entry[THR_KILL_BIT] &&
                  (!below || keep_below_level_i) &&
                  (!res.overflow || keep_overrange_i);
  assign dat_we = (state == ST_CONV) && res_pop && accept;

  // data word: tag, channel, flags and value
  always_comb begin
    dat_word = '0;
    dat_word[TAG_LSB +: 2] = TAG_DATA;
    dat_word[DAT_CHAN_LSB +: 5] = res.channel;
    dat_word[DAT_BELOW_BIT] = below;
    dat_word[DAT_OVERFLOW_BIT] = res.overflow;
    dat_word[11:0] = res.value;
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequence
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      res_cnt <= '0;
      acc_cnt <= '0;
      close_phase <= 1'b0;
      win_cnt <= '0;
      hold_cnt <= '0;
    end else if (ce_i) begin
      if (data_reset) begin
        state <= ST_IDLE;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (gate_ok) begin
              state <= ST_CONV;
              res_cnt <= '0;
              acc_cnt <= '0;
              close_phase <= 1'b0;
              win_cnt <= fast_clear_window_i;
            end
          end
          ST_CONV: begin
            if (win_cnt != 8'h00) win_cnt <= win_cnt - 8'h01;
            if (abort_rise && (win_cnt != 8'h00)) begin
              state <= ST_HOLD;
              hold_cnt <= HOLDOFF_LOAD;
            end else if (res_pop) begin
              if (accept) acc_cnt <= acc_cnt + 6'h01;
              res_cnt <= res_cnt + 6'h01;
              if (res_cnt == 6'(NUM_CHAN-1)) state <= ST_CLOSE;
            end
          end
          ST_CLOSE: begin
            close_phase <= 1'b1;
            if (close_phase || (acc_cnt == 6'h00 && !keep_empty_events_i))
              state <= ST_IDLE;
          end
          ST_HOLD: begin
            if (hold_cnt == 8'h00) state <= ST_IDLE;
            else hold_cnt <= hold_cnt - 8'h01;
          end
        endcase
      end
    end
  end

  // header first, then trailer after the data words
  assign close_write = (state == ST_CLOSE) &&
                       (acc_cnt != 6'h00 || keep_empty_events_i);
  assign wr_step = ce_i && !data_reset && close_write && close_phase;
  always_comb begin
    if (!close_phase) begin
      close_addr = {wr_event, 6'h00};
      close_word = '0;
      close_word[TAG_LSB +: 2] = TAG_HEADER;
      close_word[HDR_COUNT_LSB +: 6] = acc_cnt;
    end else begin
      close_addr = {wr_event, acc_cnt + 6'h01};
      close_word = '0;
      close_word[TAG_LSB +: 2] = TAG_TRAILER;
      close_word[23:0] = event_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event store and pointers
  assign hit_store = (bus_addr_i <= STORE_LAST);
  assign hit_thresh = (bus_addr_i >= THRESH_BASE) &&
                      (bus_addr_i <= THRESH_LAST);
  assign cur_word = store[{rd_event, rd_off}];

  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (dat_we) begin
        store[{wr_event, acc_cnt + 6'h01}] <= dat_word;
      end else if (close_write && !data_reset) begin
        store[close_addr] <= close_word;
      end
      if (bus_wr_i && hit_store) begin
        store[{rd_event, rd_off}] <= bus_wdata_i;
      end
    end
  end

  // thresholds: no reset path at all so they survive any reset
  always_ff @(posedge mclk_i) begin
    if (ce_i && bus_wr_i && hit_thresh) begin
      thresh[bus_addr_i[5:1]] <= bus_wdata_i[15:0];
    end
  end

  assign ptr_equal = (rd_event == wr_event);
  assign store_full_o = ptr_equal && last_write;
  assign store_empty_o = ptr_equal && !last_write;
  assign data_ready_o = !store_empty_o;

  assign rd_step_event = !store_empty_o && (step_event_i ||
    (read_pointer_autostep_i && bus_rd_i && hit_store &&
     (cur_word[TAG_LSB +: 2] == TAG_TRAILER ||
      rd_off == 6'(WORDS_PER_EVENT-1))));
  assign rd_step_word = !rd_step_event && (step_word_i ||
    (read_pointer_autostep_i && bus_rd_i && hit_store));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_event <= '0;
      rd_event <= '0;
      rd_off <= '0;
      last_write <= 1'b0;
    end else if (ce_i) begin
      if (data_reset) begin
        wr_event <= '0;
        rd_event <= '0;
        rd_off <= '0;
        last_write <= 1'b0;
      end else begin
        if (wr_step) wr_event <= wr_event + 5'h01;
        if (rd_step_event) begin
          rd_event <= rd_event + 5'h01;
          rd_off <= '0;
        end else if (rd_step_word) begin
          rd_off <= rd_off + 6'h01;
        end
        if (wr_step && !rd_step_event) last_write <= 1'b1;
        else if (rd_step_event && !wr_step) last_write <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= '0;
      bus_ack_o <= 1'b0;
    end else if (ce_i) begin
      bus_ack_o <= bus_rd_i || bus_wr_i;
      if (bus_rd_i) begin
        if (hit_store) bus_rdata_o <= cur_word;
        else if (hit_thresh) bus_rdata_o <= {16'h0000,
          thresh[bus_addr_i[5:1]]};
        else bus_rdata_o <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_full_is_busy: assert property (store_full_o |-> busy_o)
    else $error("full store without busy");
  a_full_empty_excl: assert property (!(store_full_o && store_empty_o))
    else $error("store both full and empty");
  a_gate_while_busy: assert property ((state != ST_IDLE && gate_rise)
    |-> !conversion_start_o)
    else $error("gate accepted while busy");
  a_holdoff_kept: assert property ((state == ST_HOLD && hold_cnt != 8'h00
    && !data_reset) |=> state == ST_HOLD)
    else $error("gate holdoff ended early");
  a_kill_blocks: assert property ((res_pop && thr_entry[THR_KILL_BIT])
    |-> !dat_we)
    else $error("killed channel stored");
  a_below_dropped: assert property ((res_pop && below
    && !keep_below_level_i) |-> !dat_we)
    else $error("below threshold result stored");
  a_overflow_dropped: assert property ((res_pop && res.overflow
    && !keep_overrange_i) |-> !dat_we)
    else $error("overflow result stored");
  a_count_mode_b: assert property ((ce_i && gate_rise && busy_o
    && !count_every_gate_i && !data_reset)
    |=> event_count == $past(event_count))
    else $error("ignored gate was counted");
  a_write_step: assert property (wr_step
    |=> wr_event == $past(wr_event) + 5'h01)
    else $error("write pointer did not advance");
  a_data_reset: assert property ((ce_i && data_reset)
    |=> store_empty_o && event_count == 24'h000000)
    else $error("data reset left state behind");
endmodule : charge_readout_control
`default_nettype wire

// file: inc/charge_readout_pkg.sv
// shared constants and types for the charge digitiser readout control
package charge_readout_pkg;
  localparam int NUM_CHAN = 32;
  localparam int NUM_EVENTS = 32;
  localparam int WORDS_PER_EVENT = 34;
  localparam int FIFO_DEPTH = 8;
  // bus address map
  localparam logic [15:0] STORE_BASE = 16'h0000;
  localparam logic [15:0] STORE_LAST = 16'h07fc;
  localparam logic [15:0] THRESH_BASE = 16'h1080;
  localparam logic [15:0] THRESH_LAST = 16'h10bf;
  // threshold entry fields
  localparam int THR_LEVEL_LSB = 0;
  localparam int THR_KILL_BIT = 8;
  // data word fields
  localparam int DAT_OVERFLOW_BIT = 12;
  localparam int DAT_BELOW_BIT = 13;
  localparam int DAT_CHAN_LSB = 16;
  localparam int TAG_LSB = 30;
  localparam logic [1:0] TAG_DATA = 2'h0;
  localparam logic [1:0] TAG_TRAILER = 2'h1;
  localparam logic [1:0] TAG_HEADER = 2'h2;
  localparam int HDR_COUNT_LSB = 8;
  // resolution shift factors: coarse x16, fine x2
  localparam int COARSE_SHIFT = 4;
  localparam int FINE_SHIFT = 1;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int GATE_HOLDOFF_NS = 600;
  localparam int GATE_HOLDOFF_CYC =
    (GATE_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HOLDOFF_LOAD = 8'(GATE_HOLDOFF_CYC - 1);

  typedef struct packed {
    logic overflow;
    logic [4:0] channel;
    logic [11:0] value;
  } result_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CONV = 4'b0010,
    ST_CLOSE = 4'b0100,
    ST_HOLD = 4'b1000
  } conv_state_type;
endpackage : charge_readout_pkg

// file: verif/host_master.sv
// host bus master model: register cycles and read pointer steps
`timescale 1ns/100ps
`default_nettype none
module host_master (
  input wire logic mclk_i,
  output logic [15:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [31:0] wdata_o,
  input wire logic [31:0] rdata_i,
  input wire logic ack_i,
  output logic step_event_o,
  output logic step_word_o
);
  initial begin
    {addr_o, wdata_o} = '0;
    {wr_o, rd_o, step_event_o, step_word_o} = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one strobe cycle, answer taken in the next cycle
  task access(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic miss);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = ~w;
    @(negedge mclk_i);
    {wr_o, rd_o} = 2'h0;
    q = rdata_i;
    miss = (ack_i !== 1'b1);
    // released lines must not hold a stale value
    addr_o = ~a;
    wdata_o = ~d;
  endtask : access
  // pointer steps when autostep is off
  task step(input logic ev);
    @(negedge mclk_i);
    step_event_o = ev;
    step_word_o = ~ev;
    @(negedge mclk_i);
    {step_event_o, step_word_o} = 2'h0;
  endtask : step
endmodule : host_master
`default_nettype wire

// file: verif/charge_readout_control_test.sv
// self-checking bench for the charge readout control block
`timescale 1ns/100ps
`default_nettype none
module charge_readout_control_test
  import charge_readout_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [15:0] bus_addr_i;
  logic bus_wr_i, bus_rd_i, step_event_i, step_word_i, bus_ack_o, miss;
  logic [31:0] bus_wdata_i, bus_rdata_o, q;
  logic keep_below_level_i = 1'b0, threshold_fine_i = 1'b0;
  logic keep_overrange_i = 1'b0, read_pointer_autostep_i = 1'b0;
  logic keep_empty_events_i = 1'b0, count_every_gate_i = 1'b1;
  logic clear_data_i = 1'b0, soft_reset_hold_i = 1'b0;
  logic single_shot_reset_i = 1'b0, front_reset_i = 1'b0;
  logic front_reset_select_i = 1'b0, gate_i = 1'b0, veto_i = 1'b0;
  logic abort_conversion_i = 1'b0, busy_from_chain_i = 1'b0;
  logic busy_source_jumper_i = 1'b0, memory_test_i = 1'b0;
  logic result_valid_i = 1'b0;
  logic [7:0] fast_clear_window_i = 8'h20;
  result_type result_i = '0;
  logic result_ready_o, conversion_start_o, charge_integrator_clear_o;
  logic busy_o, busy_led_o, global_busy_o, data_ready_o;
  logic store_full_o, store_empty_o;
  logic [15:0] event_count_low_o;
  logic [7:0] event_count_high_o;
  logic [7:0] thr_lvl [NUM_CHAN];
  logic thr_kill [NUM_CHAN];
  logic [31:0] exp_q[$], msk_q[$];
  logic last_q[$];
  int error_cnt = 0, checks_done = 0, cnt = 0, wn;

  always #2.5 mclk_i = ~mclk_i;

  charge_readout_control i_dut (.mclk_i, .rst_n_i, .ce_i, .bus_addr_i,
    .bus_wr_i, .bus_rd_i, .bus_wdata_i, .bus_rdata_o, .bus_ack_o,
    .step_event_i, .step_word_i, .keep_below_level_i, .threshold_fine_i,
    .keep_overrange_i, .read_pointer_autostep_i, .keep_empty_events_i,
    .count_every_gate_i, .clear_data_i, .soft_reset_hold_i,
    .single_shot_reset_i, .front_reset_i, .front_reset_select_i, .gate_i,
    .veto_i, .abort_conversion_i, .fast_clear_window_i, .busy_from_chain_i,
    .busy_source_jumper_i, .memory_test_i, .result_i, .result_valid_i,
    .result_ready_o, .conversion_start_o, .charge_integrator_clear_o,
    .busy_o, .busy_led_o, .global_busy_o, .data_ready_o, .store_full_o,
    .store_empty_o, .event_count_low_o, .event_count_high_o);

  host_master i_host (.mclk_i, .addr_o(bus_addr_i), .wr_o(bus_wr_i),
    .rd_o(bus_rd_i), .wdata_o(bus_wdata_i), .rdata_i(bus_rdata_o),
    .ack_i(bus_ack_o), .step_event_o(step_event_i),
    .step_word_o(step_word_i));

  ////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tick(inout int n);
    n++;
    if (n > 3000) begin
      error_cnt++;
      $display("CHECK FAILED %0t wait limit reached", $time);
      stop_test;
    end else begin
      @(negedge mclk_i);
    end
  endtask : tick

  task put(input logic [31:0] w, input logic [31:0] m, input logic l);
    exp_q.push_back(w);
    msk_q.push_back(m);
    last_q.push_back(l);
  endtask : put

  task gate_pulse(input logic acc);
    @(negedge mclk_i);
    gate_i = 1'b1;
    #1;
    chk({31'h0, conversion_start_o}, {31'h0, acc});
    if (count_every_gate_i || acc) cnt++;
    @(negedge mclk_i);
    gate_i = 1'b0;
  endtask : gate_pulse

  ////////////////////////////////////////////////////////////////////////
  // one conversion: first results wait in the fifo until the gate
  task automatic run_event(input logic all_ovf, input logic mid_gate);
    logic [31:0] body[$];
    result_type r;
    int lvl;
    logic below;
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      if (ch == FIFO_DEPTH) begin
        @(negedge mclk_i);
        result_valid_i = 1'b0;
        chk({31'h0, result_ready_o}, 32'h0);
        gate_pulse(1'b1);
        chk({30'h0, busy_o, busy_led_o}, 32'h3);
        if (mid_gate) gate_pulse(1'b0);
      end
      r.channel = 5'(ch);
      r.value = 12'($urandom % 1024);
      r.overflow = all_ovf || ($urandom % 8 == 0);
      lvl = thr_lvl[ch];
      below = threshold_fine_i ? r.value < lvl * 2 : r.value < lvl * 16;
      if (!thr_kill[ch] && (!r.overflow || keep_overrange_i) &&
          (!below || keep_below_level_i)) begin
        body.push_back({TAG_DATA, 9'h0, r.channel, 2'h0, below, r.overflow,
          r.value});
      end
      @(negedge mclk_i);
      result_i = r;
      result_valid_i = 1'b1;
      for (wn = 0; result_ready_o !== 1'b1;) tick(wn);
    end
    @(negedge mclk_i);
    result_valid_i = 1'b0;
    result_i = ~result_i;
    for (wn = 0; busy_o !== 1'b0 && store_full_o !== 1'b1;) tick(wn);
    if (body.size() > 0 || keep_empty_events_i) begin
      put({TAG_HEADER, 16'h0, 6'(body.size()), 8'h0}, 32'hc000_3f00, 1'b0);
      foreach (body[i]) put(body[i], 32'hc01f_3fff, 1'b0);
      put({TAG_TRAILER, 6'h0, 24'(cnt)}, 32'hc0ff_ffff, 1'b1);
    end
  endtask : run_event

  task read_all;
    logic [31:0] w, m;
    logic last;
    while (exp_q.size() > 0) begin
      w = exp_q.pop_front();
      m = msk_q.pop_front();
      last = last_q.pop_front();
      chk({30'h0, store_empty_o, data_ready_o}, 32'h1);
      i_host.access(1'b0, 16'($urandom % 512) << 2, 32'h0, q, miss);
      chk({31'h0, miss}, 32'h0);
      chk(q & m, w & m);
      if (!read_pointer_autostep_i) i_host.step(last);
    end
    @(negedge mclk_i);
    chk({30'h0, store_empty_o, data_ready_o}, 32'h2);
  endtask : read_all

  task thr_access(input logic w);
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      i_host.access(w, THRESH_BASE + 16'(2 * ch),
        {23'h0, thr_kill[ch], thr_lvl[ch]}, q, miss);
      chk({31'h0, miss}, 32'h0);
      if (!w) chk(q & 32'h1ff, {23'h0, thr_kill[ch], thr_lvl[ch]});
    end
  endtask : thr_access

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h6901));
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    chk({29'h0, store_empty_o, busy_o, data_ready_o}, 32'h4);
    chk({event_count_high_o, event_count_low_o}, 32'h0);
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      thr_lvl[ch] = 8'($urandom % 128);
      thr_kill[ch] = (ch % 7 == 3);
    end
    thr_access(1'b1);
    i_host.access(1'b0, 16'h2000, 32'h0, q, miss);
    chk(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      threshold_fine_i = i[0];
      keep_below_level_i = i[1];
      keep_overrange_i = i[0] ^ i[1];
      read_pointer_autostep_i = i[1];
      count_every_gate_i = (i != 2);
      run_event(1'b0, i > 1);
      chk({event_count_high_o, event_count_low_o}, 32'(cnt));
      read_all;
    end
    run_event(1'b1, 1'b0);
    chk({31'h0, store_empty_o}, 32'h1);
    keep_empty_events_i = 1'b1;
    for (int e = 0; e < NUM_EVENTS; e++) run_event(1'b1, 1'b0);
    chk({30'h0, store_full_o, busy_o}, 32'h3);
    gate_pulse(1'b0);
    read_all;
    for (int r = 0; r < 4; r++) begin
      run_event(1'b1, 1'b0);
      @(negedge mclk_i);
      clear_data_i = (r == 0);
      soft_reset_hold_i = (r == 1);
      single_shot_reset_i = (r == 2);
      front_reset_i = (r == 3);
      front_reset_select_i = 1'($urandom);
      #1 chk({30'h0, charge_integrator_clear_o, busy_o}, 32'h3);
      @(negedge mclk_i);
      {clear_data_i, soft_reset_hold_i} = 2'h0;
      {single_shot_reset_i, front_reset_i} = 2'h0;
      cnt = 0;
      exp_q.delete();
      msk_q.delete();
      last_q.delete();
      chk({event_count_high_o, event_count_low_o}, 32'h0);
      chk({31'h0, store_empty_o}, 32'h1);
    end
    thr_access(1'b0);
    gate_pulse(1'b1);
    repeat (4) @(negedge mclk_i);
    abort_conversion_i = 1'b1;
    #1 chk({31'h0, charge_integrator_clear_o}, 32'h1);
    @(negedge mclk_i);
    abort_conversion_i = 1'b0;
    repeat (60) @(negedge mclk_i);
    gate_pulse(1'b0);
    repeat (70) @(negedge mclk_i);
    chk({31'h0, store_empty_o}, 32'h1);
    run_event(1'b1, 1'b0);
    read_all;
    memory_test_i = 1'b1;
    @(negedge mclk_i);
    chk({30'h0, busy_o, busy_led_o}, 32'h3);
    gate_pulse(1'b0);
    memory_test_i = 1'b0;
    count_every_gate_i = 1'b0;
    veto_i = 1'b1;
    gate_pulse(1'b0);
    veto_i = 1'b0;
    busy_from_chain_i = 1'b1;
    busy_source_jumper_i = 1'b1;
    #1 chk({30'h0, global_busy_o, busy_o}, 32'h2);
    gate_pulse(1'b0);
    busy_source_jumper_i = 1'b0;
    run_event(1'b1, 1'b0);
    busy_from_chain_i = 1'b0;
    read_all;
    ce_i = 1'b0;
    gate_pulse(1'b0);
    ce_i = 1'b1;
    chk({event_count_high_o, event_count_low_o}, 32'(cnt));
    stop_test;
  end
endmodule : charge_readout_control_test
`default_nettype wire
